// >>> inc/clock_gen_serial_pkg.sv
package clock_gen_serial_pkg;

  // ----------------------------------------
  // Configuration image
  // ----------------------------------------
  localparam int NUM_CFG_BYTES = 8;
  localparam logic [6:0] NUM_CFG_BYTES_7 = 7'h08;
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  // Byte 0 and 1 enable every output, byte 2 has master spread on
  localparam logic [NUM_CFG_BYTES-1:0][7:0] CFG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'hFF, 8'hFF};

  // ----------------------------------------
  // Address and command fields
  // ----------------------------------------
  localparam logic [4:0] SLAVE_ADDR_BASE = 5'h1A;
  localparam int CMD_BYTE_MODE_BIT = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_RX = 3'h3,
    ST_ACK = 3'h2,
    ST_TX = 3'h6,
    ST_MACK = 3'h7,
    ST_IGNORE = 3'h5
  } port_state_t;

  typedef enum logic [1:0] {
    PH_CMD = 2'h0,
    PH_COUNT = 2'h1,
    PH_DATA = 2'h3,
    PH_DONE = 2'h2
  } byte_phase_t;

endpackage : clock_gen_serial_pkg

// >>> rtl/bus_cond_detect.sv
`timescale 1ns/10ps
module bus_cond_detect (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Conditions
  output logic scl_rise,
  output logic scl_fall,
  output logic start_cond,
  output logic stop_cond,
  output logic sda_level
);

  logic scl_ff;
  logic sda_ff;
  logic nxt_scl;
  logic nxt_sda;

  always_comb begin
    nxt_scl = scl;
    nxt_sda = sda;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= nxt_scl;
      sda_ff <= nxt_sda;
    end
  end

  // ----------------------------------------
  // Edges; data moving while clock high is start or stop
  // ----------------------------------------
  assign scl_rise = scl & ~scl_ff;
  assign scl_fall = ~scl & scl_ff;
  assign start_cond = scl & scl_ff & sda_ff & ~sda;
  assign stop_cond = scl & scl_ff & ~sda_ff & sda;
  assign sda_level = sda_ff;

endmodule : bus_cond_detect

// >>> rtl/clock_gen_serial_slave_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// (R01) Config bytes take defaults at reset
// (R02) Ignore bus while powered down
// (R03) Byte/block write and read supported
// (R04) Answer only strapped address D0..D6
// (R05) Command bit 7: 0 block, 1 byte
// (R06) Byte mode offset from command bits 6:0
// (R07) Master sends zero command for block
// (R08) Block bytes ascending from zero, MSB first
// (R09) Stop after any byte keeps written bytes
// (R10) Block write: addr, cmd, count, data, stop
// (R11) Ack address, command, count, every data
// (R12) Block read returns count then data
// (R13) Master nacks last read byte then stops
// (R14) Byte write: addr, cmd, one data, acked
// (R15) Byte read returns one indexed byte
// (R16) Enable bits drive clock outputs, default on
// (R17) Wrong address: release line until start
// (R18) Start or stop abandons partial byte
module clock_gen_serial_slave_port
  import clock_gen_serial_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Device state
  input wire logic power_down,
  input wire logic [1:0] slave_addr_select_straps,
  // Serial bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Configuration image
  output logic [NUM_CFG_BYTES-1:0][7:0] config_bytes,
  output logic [15:0] clock_output_enable
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  port_state_t state_ff, nxt_state;
  byte_phase_t phase_ff, nxt_phase;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shreg_ff, nxt_shreg;
  logic [6:0] idx_ff, nxt_idx;
  logic [7:0] left_ff, nxt_left;
  logic block_ff, nxt_block;
  logic rd_ff, nxt_rd;
  logic first_ff, nxt_first;
  logic oe_n_ff, nxt_oe_n;
  logic [NUM_CFG_BYTES-1:0][7:0] cfg_ff, nxt_cfg;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic sda_level;

  bus_cond_detect u_cond (
    .clock(clock),
    .rst_n(rst_n),
    .scl(scl),
    .sda(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_cond(start_cond),
    .stop_cond(stop_cond),
    .sda_level(sda_level)
  );

  // Out of range offsets read as zero rather than aliasing
  function automatic logic [7:0] cfg_read(input logic [NUM_CFG_BYTES-1:0][7:0] img, input logic [6:0] idx);
    logic [7:0] val;
    val = 8'h00;
    if (idx < NUM_CFG_BYTES_7) begin
      val = img[idx[2:0]];
    end
    return val;
  endfunction : cfg_read

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_shreg = shreg_ff;
    nxt_idx = idx_ff;
    nxt_left = left_ff;
    nxt_block = block_ff;
    nxt_rd = rd_ff;
    nxt_first = first_ff;
    nxt_oe_n = oe_n_ff;
    nxt_cfg = cfg_ff;
    if (power_down) begin
      nxt_state = ST_IDLE; // R02
      nxt_oe_n = 1'b1;
    end else if (start_cond) begin
      nxt_state = ST_ADDR; // R18
      nxt_cnt = 4'h0;
      nxt_oe_n = 1'b1;
    end else if (stop_cond) begin
      nxt_state = ST_IDLE; // R18 R09
      nxt_oe_n = 1'b1;
    end else begin
      unique case (state_ff)
        ST_IDLE, ST_IGNORE: begin
          nxt_oe_n = 1'b1; // R17
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise && cnt_ff < BITS_PER_BYTE) begin
            nxt_shreg = {shreg_ff[6:0], sda_level}; // R08
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            nxt_cnt = 4'h0;
            nxt_state = ST_ACK;
            nxt_oe_n = 1'b0; // R11 R14
            if (state_ff == ST_ADDR) begin
              if (shreg_ff[7:1] == {SLAVE_ADDR_BASE, slave_addr_select_straps}) begin // R04
                nxt_rd = shreg_ff[0];
                nxt_first = 1'b1;
                if (!shreg_ff[0]) begin
                  nxt_phase = PH_CMD;
                end
              end else begin
                nxt_state = ST_IGNORE; // R17
                nxt_oe_n = 1'b1;
              end
            end else begin
              unique case (phase_ff)
                PH_CMD: begin
                  nxt_block = ~shreg_ff[CMD_BYTE_MODE_BIT]; // R05 R07
                  nxt_idx = shreg_ff[CMD_BYTE_MODE_BIT] ? shreg_ff[6:0] : 7'h00; // R06
                  nxt_phase = shreg_ff[CMD_BYTE_MODE_BIT] ? PH_DATA : PH_COUNT;
                end
                PH_COUNT: begin
                  nxt_left = shreg_ff; // R10
                  nxt_phase = PH_DATA;
                end
                PH_DATA: begin
                  if ((!block_ff || left_ff != 8'h00) && idx_ff < NUM_CFG_BYTES_7) begin
                    nxt_cfg[idx_ff[2:0]] = shreg_ff; // R03 R09
                  end
                  nxt_idx = idx_ff + 7'h01; // R08
                  if (left_ff != 8'h00) begin
                    nxt_left = left_ff - 8'h01;
                  end
                  if (!block_ff) begin
                    nxt_phase = PH_DONE; // R14
                  end
                end
                PH_DONE: begin
                  nxt_phase = PH_DONE;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rd_ff) begin
              if (block_ff && first_ff) begin
                nxt_shreg = BLOCK_COUNT; // R12
              end else begin
                nxt_shreg = cfg_read(cfg_ff, idx_ff); // R15 R08
                nxt_idx = idx_ff + 7'h01;
              end
              nxt_first = 1'b0;
              nxt_oe_n = nxt_shreg[7];
              nxt_state = ST_TX;
            end else begin
              nxt_oe_n = 1'b1;
              nxt_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == LAST_TX_BIT) begin
              nxt_cnt = 4'h0;
              nxt_oe_n = 1'b1;
              nxt_state = ST_MACK;
            end else begin
              nxt_shreg = {shreg_ff[6:0], 1'b0};
              nxt_oe_n = shreg_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // Nack ends the read; a stop is then expected
          if (scl_rise) begin
            nxt_state = sda_level ? ST_IGNORE : ST_ACK; // R13
          end
        end
        // Unused code: fall back to idle with the line released
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_CMD;
      cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      idx_ff <= 7'h00;
      left_ff <= 8'h00;
      block_ff <= 1'b0;
      rd_ff <= 1'b0;
      first_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      cfg_ff <= CFG_RESET; // R01 R16
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      shreg_ff <= nxt_shreg;
      idx_ff <= nxt_idx;
      left_ff <= nxt_left;
      block_ff <= nxt_block;
      rd_ff <= nxt_rd;
      first_ff <= nxt_first;
      oe_n_ff <= nxt_oe_n;
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_ff;
  assign config_bytes = cfg_ff;
  assign clock_output_enable = {cfg_ff[0], cfg_ff[1]}; // R16

endmodule : clock_gen_serial_slave_port

// >>> verification/serial_master_model.sv
`timescale 1ns/10ps
module serial_master_model (
  // Clock
  input wire logic clock,
  // Device pin
  input wire logic sda_oe_n,
  input wire logic sda_out,
  // Bus
  output logic scl,
  output logic sda
);
  logic drv;
  // Pull-up: a released line reads high
  assign sda = drv & (sda_oe_n | sda_out);
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask : hold
  // Start when s, else stop; data is set up with scl low, then moves with scl high
  task automatic bus_cond(input logic s);
    drv = s;
    hold(4);
    scl = 1'b1;
    hold(4);
    drv = ~s;
    hold(4);
    scl = ~s;
  endtask : bus_cond
  // Slow bit keeps data settled well around the rise
  task automatic bitx(input logic b, output logic r);
    drv = b;
    hold(4);
    scl = 1'b1;
    hold(4);
    r = sda;
    scl = 1'b0;
    hold(4);
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(mack, ack);
  endtask : xfer
endmodule : serial_master_model

// >>> verification/clock_gen_serial_monitor.sv
`timescale 1ns/10ps
module clock_gen_serial_slave_port_monitor
  import clock_gen_serial_pkg::*;
(
  // Clock and mode
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_down,
  // Bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  // Image
  input wire logic [NUM_CFG_BYTES-1:0][7:0] config_bytes,
  input wire logic [15:0] clock_output_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_RST_VAL: assert property ($rose(rst_n) |-> config_bytes == CFG_RESET && sda_oe_n) else $error("reset");
  AST_ENA_MAP: assert property (clock_output_enable == {config_bytes[0], config_bytes[1]}) else $error("map");
  AST_PD_REL: assert property (power_down |=> sda_oe_n) else $error("pd drive");
  AST_PD_CFG: assert property (power_down [*2] |=> $stable(config_bytes)) else $error("pd write");
  AST_OE_SCL: assert property ($changed(sda_oe_n) && $past(rst_n) && !$past(power_down) |-> !$past(scl))
    else $error("sda moved");
  AST_CFG_SCL: assert property ($changed(config_bytes) && $past(rst_n) |-> !$past(scl)) else $error("write");
  AST_DRV_HOLD: assert property (!sda_oe_n && scl && !power_down |=> !sda_oe_n) else $error("hold");
  AST_STOP_REL: assert property (scl && $past(scl) && $rose(sda_in) |=> sda_oe_n [*2]) else $error("stop");
  cover property ($fell(sda_oe_n));
  cover property ($changed(config_bytes) && $past(rst_n));
  cover property (power_down ##1 !power_down);
endmodule : clock_gen_serial_slave_port_monitor

bind clock_gen_serial_slave_port clock_gen_serial_slave_port_monitor mon (.clock(clock), .rst_n(rst_n),
  .power_down(power_down), .scl(scl), .sda_in(sda_in), .sda_oe_n(sda_oe_n), .config_bytes(config_bytes),
  .clock_output_enable(clock_output_enable));

// >>> verification/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  import clock_gen_serial_pkg::*;
  logic clock, rst_n, power_down;
  logic [1:0] straps;
  logic scl, sda, sda_out, sda_oe_n, ack;
  logic [NUM_CFG_BYTES-1:0][7:0] config_bytes;
  logic [15:0] clock_output_enable;
  logic [7:0] rd;
  int num_errors = 0, n_tests = 0;
  always #5 clock = ~clock;
  clock_gen_serial_slave_port uut (.clock(clock), .rst_n(rst_n), .power_down(power_down),
    .slave_addr_select_straps(straps), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .config_bytes(config_bytes), .clock_output_enable(clock_output_enable));
  serial_master_model m (.clock(clock), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl), .sda(sda));
  task automatic wr(input logic [7:0] d, input logic e);
    m.xfer(d, 1'b1, rd, ack);
    `CHK("ack", e, ack)
  endtask : wr
  task automatic rdb(input logic mack, input logic [7:0] e);
    m.xfer(8'hFF, mack, rd, ack);
    `CHK("data", e, rd)
  endtask : rdb
  task automatic hdr(input logic [7:0] cmd, input logic rd_op);
    m.bus_cond(1'b1);
    wr(8'hD0, 1'b0);
    wr(cmd, 1'b0);
    if (rd_op) begin
      m.bus_cond(1'b1);
      wr(8'hD1, 1'b0);
    end
  endtask : hdr
  task automatic t_byte();
    hdr(8'h83, 1'b0);
    wr(8'hA5, 1'b0);
    m.bus_cond(1'b0);
    `CHK("byte3", 8'hA5, config_bytes[3])
    hdr(8'h83, 1'b1);
    rdb(1'b1, 8'hA5);
    m.bus_cond(1'b0);
    // Offset past the image: write dropped, read gives zero
    hdr(8'h8A, 1'b0);
    wr(8'h5C, 1'b0);
    m.bus_cond(1'b0);
    `CHK("byte2", CFG_RESET[2], config_bytes[2])
    hdr(8'h8A, 1'b1);
    rdb(1'b1, 8'h00);
    m.bus_cond(1'b0);
  endtask : t_byte
  // Stops early: byte 3 must keep its value
  task automatic t_block();
    hdr(8'h00, 1'b0);
    wr(8'h08, 1'b0);
    for (int i = 1; i < 4; i++) wr(8'(i * 8'h11), 1'b0);
    m.bus_cond(1'b0);
    `CHK("image", 32'hA5332211, config_bytes[3:0])
    `CHK("enable", 16'h1122, clock_output_enable)
    hdr(8'h00, 1'b1);
    rdb(1'b0, BLOCK_COUNT);
    for (int i = 1; i < 4; i++) rdb(i == 3, 8'(i * 8'h11));
    m.bus_cond(1'b0);
  endtask : t_block
  task automatic t_addr();
    for (int i = 0; i < 4; i++) begin
      straps = 2'(i);
      m.bus_cond(1'b1);
      wr({5'h1A, straps, 1'b0}, 1'b0);
      m.bus_cond(1'b1);
      wr({5'h1A, ~straps, 1'b0}, 1'b1);
      wr(8'h80, 1'b1);
      m.bus_cond(1'b0);
    end
    straps = 2'h0;
  endtask : t_addr
  task automatic t_pd();
    power_down = 1'b1;
    m.bus_cond(1'b1);
    wr(8'hD0, 1'b1);
    wr(8'h82, 1'b1);
    wr(8'h5A, 1'b1);
    m.bus_cond(1'b0);
    power_down = 1'b0;
    hdr(8'h82, 1'b0);
    for (int i = 0; i < 4; i++) m.bitx(1'b0, ack);
    m.bus_cond(1'b0);
    `CHK("byte2", 8'h33, config_bytes[2])
  endtask : t_pd
  // Reset in mid-frame must bring back every default
  task automatic t_rst();
    hdr(8'h80, 1'b0);
    wr(8'h00, 1'b0);
    `CHK("enable", 16'h0022, clock_output_enable)
    rst_n = 1'b0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    m.bus_cond(1'b0);
    `CHK("image", CFG_RESET, config_bytes)
    `CHK("enable", 16'hFFFF, clock_output_enable)
    hdr(8'h80, 1'b1);
    rdb(1'b1, 8'hFF);
    m.bus_cond(1'b0);
  endtask : t_rst
  task automatic results();
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    power_down = 1'b0;
    straps = 2'h0;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHK("image", CFG_RESET, config_bytes)
    `CHK("enable", 16'hFFFF, clock_output_enable)
    `CHK("sda_out", 1'b0, sda_out)
    t_byte();
    t_block();
    t_addr();
    t_pd();
    t_rst();
    results();
  end
endmodule : testbench
